// ---- pci_cmd_pkg.sv ----
package pci_cmd_pkg;

  localparam int unsigned NUM_FUNCS = 2;

  // configuration offsets (ID half at 0x02) and dword-alignment mask
  localparam logic [7:0] CFG_ID_DWORD   = 8'h00;
  localparam logic [7:0] CFG_ID_OFFSET  = 8'h02;
  localparam logic [7:0] CFG_CMD_OFFSET = 8'h04;
  localparam logic [7:0] CFG_DWORD_MASK = 8'hFC;

  // command register field positions
  localparam int unsigned CMD_IO_BIT      = 0;
  localparam int unsigned CMD_MEM_BIT     = 1;
  localparam int unsigned CMD_MASTER_BIT  = 2;
  localparam int unsigned CMD_SPECIAL_BIT = 3;
  localparam int unsigned CMD_WRINV_BIT   = 4;
  localparam int unsigned CMD_SNOOP_BIT   = 5;
  localparam int unsigned CMD_PERR_BIT    = 6;
  localparam int unsigned CMD_STEP_BIT    = 7;
  localparam int unsigned CMD_SERR_BIT    = 8;
  localparam int unsigned CMD_B2B_BIT     = 9;

  localparam logic [15:0] CMD_RESET_VALUE = 16'h0000;
  localparam logic [15:0] CMD_WRITE_MASK  = 16'h0167;
  localparam logic [15:0] ZERO_HALF       = 16'h0000;

  // identity code: value is arbitrary
  localparam logic [15:0] PART_CODE_DEFAULT = 16'h5A5A;

  // configuration access sequencer
  typedef enum logic [0:0] {
    CFG_IDLE   = 1'b0,
    CFG_ANSWER = 1'b1
  } cfg_state_t;

endpackage

// ---- cmd_reg_slice.sv ----
// one function's command register
module cmd_reg_slice (
  input  wire logic        sys_clk,  // system clock
  input  wire logic        reset,    // async reset, active high
  input  wire logic        clk_en,   // freezes state when low
  input  wire logic        wr_stb,   // config write to command offset
  input  wire logic [1:0]  wr_be,    // byte enables, low half of dword
  input  wire logic [15:0] wr_data,  // write data, low half of dword
  output logic      [15:0] cmd       // current command value
);

  typedef struct packed {
    logic [15:0] cmd;
  } slice_state_t;

  slice_state_t st_q;
  slice_state_t st_d;

  always_comb begin
    st_d = st_q;
    if (wr_stb) begin
      if (wr_be[0]) begin
        st_d.cmd[7:0] = wr_data[7:0] & pci_cmd_pkg::CMD_WRITE_MASK[7:0];
      end
      if (wr_be[1]) begin
        st_d.cmd[15:8] = wr_data[15:8] & pci_cmd_pkg::CMD_WRITE_MASK[15:8];
      end
    end
    // read-only bits never leave zero
    st_d.cmd = st_d.cmd & pci_cmd_pkg::CMD_WRITE_MASK;
  end

  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      st_q.cmd <= pci_cmd_pkg::CMD_RESET_VALUE;
    end else if (clk_en) begin
      st_q <= st_d;
    end
  end

  assign cmd = st_q.cmd;

endmodule

// ---- pci_function_command_regs.sv ----
module pci_function_command_regs #(
  parameter logic [15:0] PART_CODE = pci_cmd_pkg::PART_CODE_DEFAULT // arbitrary
) (
  input  wire logic        sys_clk,             // system clock
  input  wire logic        reset,               // async reset, active high
  input  wire logic        clk_en,              // freezes state when low
  input  wire logic        cfg_req,             // configuration cycle request
  input  wire logic        cfg_we,              // 1 write, 0 read
  input  wire logic        cfg_func,            // target function number
  input  wire logic [7:0]  cfg_addr,            // byte offset in header
  input  wire logic [3:0]  cfg_be,              // byte enables
  input  wire logic [31:0] cfg_wdata,           // write data
  output logic             cfg_ack,             // answer strobe
  output logic      [31:0] cfg_rdata,           // read data
  input  wire logic [1:0]  io_hit,              // I/O address decoded
  input  wire logic [1:0]  mem_hit,             // memory address decoded
  input  wire logic [1:0]  palette_write_hit,   // palette register write seen
  input  wire logic [1:0]  initiator_want,      // function wants the bus
  input  wire logic        addr_parity_error,   // address parity fault
  input  wire logic        data_parity_error,   // data parity fault
  output logic      [1:0]  io_claim,            // claim I/O cycle
  output logic      [1:0]  mem_claim,           // claim memory cycle
  output logic      [1:0]  palette_capture,     // latch snooped palette data
  output logic      [1:0]  bus_request,         // initiator request
  output logic      [1:0]  palette_snoop_mode,  // snoop bit per function
  output logic             system_error_drive_enable, // ORed bit 8
  output logic             parity_response_enable,    // ORed bit 6
  output logic             back_to_back_initiate_enable, // always zero
  output logic             write_invalidate_enable,      // always zero
  output logic             perr_n_o,            // parity error pin value
  output logic             perr_n_oe,           // parity error pin drive
  output logic             serr_n_o,            // system error pin value
  output logic             serr_n_oe            // system error pin drive
);

  typedef struct packed {
    pci_cmd_pkg::cfg_state_t fsm;
    logic [31:0]             rdata;
    logic [1:0]              io_claim;
    logic [1:0]              mem_claim;
    logic [1:0]              pal_cap;
    logic [1:0]              bus_req;
    logic                    serr;
    logic                    perr;
  } top_state_t;

  top_state_t st_q;
  top_state_t st_d;

  logic [15:0] cmd [pci_cmd_pkg::NUM_FUNCS];
  logic [1:0]  io_en;
  logic [1:0]  mem_en;
  logic [1:0]  mst_en;
  logic [1:0]  snoop_en;
  logic [1:0]  perr_bits;
  logic [1:0]  serr_bits;
  logic [7:0]  dword_addr;
  logic        cmd_wr_hit;
  logic        serr_any;
  logic        perr_any;

  assign dword_addr = cfg_addr & pci_cmd_pkg::CFG_DWORD_MASK;
  assign cmd_wr_hit = cfg_req && cfg_we && (st_q.fsm == pci_cmd_pkg::CFG_IDLE)
                      && (dword_addr == pci_cmd_pkg::CFG_CMD_OFFSET);

  for (genvar f = 0; f < pci_cmd_pkg::NUM_FUNCS; f++) begin : g_func
    cmd_reg_slice u_cmd (
      .sys_clk (sys_clk),
      .reset   (reset),
      .clk_en  (clk_en),
      .wr_stb  (cmd_wr_hit && (cfg_func == 1'(f))),
      .wr_be   (cfg_be[1:0]),
      .wr_data (cfg_wdata[15:0]),
      .cmd     (cmd[f])
    );
    assign io_en[f]     = cmd[f][pci_cmd_pkg::CMD_IO_BIT];
    assign mem_en[f]    = cmd[f][pci_cmd_pkg::CMD_MEM_BIT];
    assign mst_en[f]    = cmd[f][pci_cmd_pkg::CMD_MASTER_BIT];
    assign snoop_en[f]  = cmd[f][pci_cmd_pkg::CMD_SNOOP_BIT];
    assign perr_bits[f] = cmd[f][pci_cmd_pkg::CMD_PERR_BIT];
    assign serr_bits[f] = cmd[f][pci_cmd_pkg::CMD_SERR_BIT];
  end

  // error enables are shared between functions
  assign serr_any = |serr_bits;
  assign perr_any = |perr_bits;

  always_comb begin
    st_d = st_q;
    // configuration access: one-cycle answer
    case (st_q.fsm)
      pci_cmd_pkg::CFG_IDLE: begin
        if (cfg_req) begin
          st_d.fsm   = pci_cmd_pkg::CFG_ANSWER;
          st_d.rdata = 32'h0000_0000;
          if (!cfg_we) begin
            if (dword_addr == pci_cmd_pkg::CFG_ID_DWORD) begin
              st_d.rdata = {PART_CODE, pci_cmd_pkg::ZERO_HALF};
            end else if (dword_addr == pci_cmd_pkg::CFG_CMD_OFFSET) begin
              // per-function copy, read-only bits already zero
              st_d.rdata = {pci_cmd_pkg::ZERO_HALF, cmd[cfg_func]};
            end
          end
        end
      end
      pci_cmd_pkg::CFG_ANSWER: begin
        st_d.fsm = pci_cmd_pkg::CFG_IDLE;
      end
      default: begin
        st_d.fsm = pci_cmd_pkg::CFG_IDLE;
      end
    endcase

    // target decode, palette writes not claimed as I/O while snooping; memory claims unmasked
    st_d.io_claim  = io_hit & io_en & ~(palette_write_hit & snoop_en);
    st_d.mem_claim = mem_hit & mem_en;
    st_d.pal_cap   = palette_write_hit & snoop_en;
    st_d.bus_req   = initiator_want & mst_en;

    // address parity needs both enables, data parity too
    st_d.serr = serr_any && perr_any
                && (addr_parity_error || data_parity_error);
    st_d.perr = perr_any && data_parity_error;
  end

  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      st_q.fsm       <= pci_cmd_pkg::CFG_IDLE;
      st_q.rdata     <= 32'h0000_0000;
      st_q.io_claim  <= 2'h0;
      st_q.mem_claim <= 2'h0;
      st_q.pal_cap   <= 2'h0;
      st_q.bus_req   <= 2'h0;
      st_q.serr      <= 1'b0;
      st_q.perr      <= 1'b0;
    end else if (clk_en) begin
      st_q <= st_d;
    end
  end

  assign cfg_ack         = (st_q.fsm == pci_cmd_pkg::CFG_ANSWER);
  assign cfg_rdata       = st_q.rdata;
  assign io_claim        = st_q.io_claim;
  assign mem_claim       = st_q.mem_claim;
  assign palette_capture = st_q.pal_cap;
  assign bus_request     = st_q.bus_req;
  assign palette_snoop_mode = snoop_en;

  assign system_error_drive_enable    = serr_any;
  assign parity_response_enable       = perr_any;
  assign back_to_back_initiate_enable = 1'b0;
  assign write_invalidate_enable      = 1'b0;

  // open-drain pins pull low only when armed
  assign serr_n_o  = 1'b0;
  assign serr_n_oe = st_q.serr && serr_any;
  assign perr_n_o  = 1'b0;
  assign perr_n_oe = st_q.perr;

  // stepping and special cycles: bits 7 and 3 masked in the slice

endmodule

// ---- cmd_regs_properties.sv ----
module cmd_regs_properties (
  input wire logic       sys_clk,
  input wire logic       reset,
  input wire logic       clk_en,
  input wire logic       cfg_req,
  input wire logic       cfg_ack,
  input wire logic [1:0] io_hit,
  input wire logic [1:0] palette_write_hit,
  input wire logic       addr_parity_error,
  input wire logic       data_parity_error,
  input wire logic [1:0] io_claim,
  input wire logic [1:0] palette_capture,
  input wire logic [1:0] palette_snoop_mode,
  input wire logic       system_error_drive_enable,
  input wire logic       parity_response_enable,
  input wire logic       back_to_back_initiate_enable,
  input wire logic       write_invalidate_enable,
  input wire logic       perr_n_oe,
  input wire logic       serr_n_oe
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (reset);
  sequence taken_s;
    cfg_req && clk_en && !cfg_ack;
  endsequence
  sequence answer_s;
    cfg_ack ##1 !cfg_ack;
  endsequence
  ack_timing_a: assert property (taken_s |=> answer_s)
    else $error("config answer is not one pulse one cycle after request");
  b2b_zero_a: assert property (!back_to_back_initiate_enable)
    else $error("back to back enable seen high");
  wrinv_zero_a: assert property (!write_invalidate_enable)
    else $error("write invalidate enable seen high");
  io_claim_a: assert property ((io_claim & ~$past(io_hit)) == 2'h0)
    else $error("io claim without a decoded hit");
  palette_capture_a: assert property (
    (palette_capture & ~$past(palette_write_hit & palette_snoop_mode)) == 2'h0)
    else $error("palette capture without snoop mode");
  serr_cause_a: assert property (serr_n_oe |-> system_error_drive_enable &&
    $past((addr_parity_error || data_parity_error) && parity_response_enable))
    else $error("system error driven without cause");
  serr_fire_a: assert property (addr_parity_error && clk_en &&
    system_error_drive_enable && parity_response_enable |=> serr_n_oe)
    else $error("system error not driven after address parity fault");
  perr_gate_a: assert property (perr_n_oe |->
    $past(data_parity_error && parity_response_enable))
    else $error("parity error driven while response disabled");
endmodule

bind pci_function_command_regs cmd_regs_properties chk_inst (.*);

// ---- cfg_host.sv ----
module cfg_host (
  input  wire logic        sys_clk,   // bus clock
  input  wire logic        cfg_ack,   // answer strobe
  input  wire logic [31:0] cfg_rdata, // read data
  output logic             cfg_req,   // request
  output logic             cfg_we,    // write select
  output logic             cfg_func,  // function number
  output logic      [7:0]  cfg_addr,  // offset
  output logic      [3:0]  cfg_be,    // byte enables
  output logic      [31:0] cfg_wdata  // write data
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    cfg_req = 1'b0;
    {cfg_we, cfg_func, cfg_addr, cfg_be, cfg_wdata} = '0;
  end
  // config cycle held until the edge that samples the answer
  task automatic xfer(input logic we, input logic f, input logic [7:0] a,
                      input logic [3:0] be, input logic [31:0] d,
                      output logic [31:0] rd);
    {cfg_req, cfg_we, cfg_func, cfg_addr, cfg_be, cfg_wdata} = {1'b1, we, f, a, be, d};
    @(negedge sys_clk);
    for (int n = 0; n < 20 && cfg_ack !== 1'b1; n++) @(negedge sys_clk);
    @(posedge sys_clk);
    rd = cfg_rdata;
    @(negedge sys_clk);
    // released lines show inverted garbage
    {cfg_req, cfg_we, cfg_addr, cfg_be, cfg_wdata} = {1'b0, ~we, ~a, ~be, ~d};
    @(negedge sys_clk);
  endtask
endmodule

// ---- pci_function_command_regs_tb.sv ----
module pci_function_command_regs_tb;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [15:0] CODE = 16'h3C3C; // arbitrary identity value
  logic sys_clk, reset, clk_en, cfg_req, cfg_we, cfg_func, cfg_ack;
  logic [7:0] cfg_addr;
  logic [3:0] cfg_be;
  logic [31:0] cfg_wdata, cfg_rdata;
  logic [1:0] io_hit, mem_hit, palette_write_hit, initiator_want, io_claim, mem_claim;
  logic [1:0] palette_capture, bus_request, palette_snoop_mode;
  logic addr_parity_error, data_parity_error, system_error_drive_enable;
  logic parity_response_enable, back_to_back_initiate_enable, write_invalidate_enable;
  logic perr_n_o, perr_n_oe, serr_n_o, serr_n_oe;
  int errors = 0, n_checks = 0, cycles = 0;
  pci_function_command_regs #(.PART_CODE(CODE)) pci_function_command_regs_inst (.*);
  cfg_host cfg_host_inst (.*);
  initial begin
    sys_clk = 1'b0;
    forever #5 sys_clk = ~sys_clk;
  end
  task automatic chk(logic [31:0] got, logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      errors++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic give_verdict;
    $display("checks=%0d errors=%0d", n_checks, errors);
    if (errors == 0 && n_checks > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  task automatic wr(logic f, logic [7:0] a, logic [3:0] be, logic [31:0] d);
    logic [31:0] x;
    cfg_host_inst.xfer(1'b1, f, a, be, d, x);
  endtask
  task automatic rd(logic f, logic [7:0] a, logic [31:0] e);
    logic [31:0] x;
    cfg_host_inst.xfer(1'b0, f, a, 4'hF, 32'h0000_0000, x);
    chk(x, e);
  endtask
  task automatic pulse(logic a, logic d);
    {addr_parity_error, data_parity_error} = {a, d};
    @(negedge sys_clk);
    {addr_parity_error, data_parity_error} = 2'h0;
  endtask
  task automatic t_reset_id;
    rd(1'b0, 8'h04, 32'h0000_0000);
    rd(1'b1, 8'h04, 32'h0000_0000);
    wr(1'b0, 8'h00, 4'hF, 32'hFFFF_FFFF);
    rd(1'b1, 8'h00, {CODE, 16'h0000});
    rd(1'b0, 8'h02, {CODE, 16'h0000});
  endtask
  task automatic t_write_mask;
    wr(1'b0, 8'h04, 4'hF, 32'hFFFF_FFFF);
    rd(1'b0, 8'h04, 32'h0000_0167);
    rd(1'b1, 8'h04, 32'h0000_0000);
    wr(1'b1, 8'h04, 4'h2, 32'hFFFF_FFFF);
    rd(1'b1, 8'h04, 32'h0000_0100);
    wr(1'b1, 8'h04, 4'h1, 32'hFFFF_FF20);
    rd(1'b1, 8'h04, 32'h0000_0120);
  endtask
  task automatic t_decode;
    {io_hit, mem_hit, palette_write_hit, initiator_want} = 8'hF3;
    repeat (2) @(negedge sys_clk);
    chk({io_claim, mem_claim, bus_request, palette_capture}, 32'h54);
    {io_hit, mem_hit, palette_write_hit, initiator_want} = 8'hFF;
    repeat (2) @(negedge sys_clk);
    chk({io_claim, mem_claim, bus_request, palette_capture}, 32'h17);
    chk({30'h0, palette_snoop_mode}, 32'h3);
    {io_hit, mem_hit, palette_write_hit, initiator_want} = 8'h00;
  endtask
  task automatic t_errors;
    chk({system_error_drive_enable, parity_response_enable}, 32'h3);
    pulse(1'b1, 1'b0);
    chk({serr_n_oe, serr_n_o}, 32'h2);
    wr(1'b0, 8'h04, 4'h3, 32'h0000_0100);
    pulse(1'b1, 1'b1);
    chk({serr_n_oe, perr_n_oe, parity_response_enable}, 32'h0);
    wr(1'b1, 8'h04, 4'h3, 32'h0000_0040);
    pulse(1'b0, 1'b1);
    chk({serr_n_oe, perr_n_oe, perr_n_o}, 32'h6);
  endtask
  always @(posedge sys_clk) begin
    cycles++;
    if (cycles == 3000) begin
      errors++;
      give_verdict();
    end
  end
  initial begin
    {reset, clk_en, addr_parity_error, data_parity_error} = 4'hC;
    {io_hit, mem_hit, palette_write_hit, initiator_want} = 8'h00;
    repeat (16) @(posedge sys_clk);
    @(negedge sys_clk);
    reset = 1'b0;
    @(negedge sys_clk);
    t_reset_id();
    t_write_mask();
    t_decode();
    t_errors();
    give_verdict();
  end
endmodule
